// *** rtl/bsfc_pkg.sv ***
// Shared constants, register map and state encoding of the boot flash host controller.
// Assumes a single 40 MHz clock and a parallel flash wired to the controller's pins.
package bsfc_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;

	// Register byte offsets on the AXI4-Lite port.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_CMD    = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA  = 8'h14;

	// Control register fields and reset values.
	localparam int         CTRL_BYTE     = 0;
	localparam int         CTRL_STANDBY  = 1;
	localparam int         CTRL_RESET    = 2;
	localparam logic       BYTE_RST      = 1'b0;
	localparam logic       STANDBY_RST   = 1'b0;
	localparam logic       RESET_RST     = 1'b0;

	// Status register fields.
	localparam int         STAT_BUSY     = 0;
	localparam int         STAT_READY    = 1;
	localparam int         STAT_DONE     = 2;
	localparam int         STAT_REFUSED  = 3;

	// Command register operation codes.
	localparam logic [1:0] OP_NONE  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_POLL  = 2'h3;

	localparam int         TOGGLE_BIT = 6;
	localparam int         POLL_BIT   = 7;

	// Pin timing, each figure in ns, then in whole clock cycles rounded up.
	localparam int         CLK_PERIOD_NS = 25;
	localparam int         SETUP_NS      = 25;
	localparam int         STROBE_NS     = 200;
	localparam int         HOLD_NS       = 25;
	localparam logic [3:0] SETUP_CYC     = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] STROBE_CYC    = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] HOLD_CYC      = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		BSFC_IDLE   = 5'h01,
		BSFC_SETUP  = 5'h02,
		BSFC_STROBE = 5'h04,
		BSFC_HOLD   = 5'h08,
		BSFC_CMPR   = 5'h10
	} bsfc_state_t;

endpackage

// *** rtl/bsfc_axil_slave.sv ***
// AXI4-Lite slave front end of the flash host controller.
// Assumes the register file answers decode and read data combinationally on the same clock.
`timescale 1ns/1ps
module bsfc_axil_slave (
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic             reg_wr_out,
	output logic [7:0]       reg_wr_addr_out,
	output logic [31:0]      reg_wdata_out,
	output logic [3:0]       reg_wstrb_out,
	input  wire logic        reg_wr_err_in,
	output logic [7:0]       reg_rd_addr_out,
	input  wire logic [31:0] reg_rdata_in,
	input  wire logic        reg_rd_err_in
);

	typedef struct packed {
		logic        aw_have;
		logic [7:0]  awaddr;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        wr_pulse;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} bsfc_axi_state_t;

	bsfc_axi_state_t s;
	bsfc_axi_state_t next_s;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_s = s;
		next_s.wr_pulse = 1'b0;
		if (s_axi_awvalid_in && s.awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr  = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s.wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata  = s_axi_wdata_in;
			next_s.wstrb  = s_axi_wstrb_in;
		end
		if (s.aw_have && s.w_have && !s.wr_pulse && !s.bvalid) begin
			next_s.wr_pulse = 1'b1;
		end
		// The decode answer is sampled in the pulse cycle, so the response lags one cycle.
		if (s.wr_pulse) begin
			next_s.bvalid  = 1'b1;
			next_s.bresp   = reg_wr_err_in ? bsfc_pkg::RESP_SLVERR : bsfc_pkg::RESP_OKAY;
			next_s.aw_have = 1'b0;
			next_s.w_have  = 1'b0;
		end
		if (s.bvalid && s_axi_bready_in) begin
			next_s.bvalid = 1'b0;
		end
		next_s.awready = !next_s.aw_have && !next_s.bvalid && !next_s.wr_pulse;
		next_s.wready  = !next_s.w_have && !next_s.bvalid && !next_s.wr_pulse;
		if (s_axi_arvalid_in && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid  = 1'b1;
			next_s.rdata   = reg_rdata_in;
			next_s.rresp   = reg_rd_err_in ? bsfc_pkg::RESP_SLVERR : bsfc_pkg::RESP_OKAY;
		end else if (s.rvalid && s_axi_rready_in) begin
			next_s.rvalid  = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			s         <= '0;
			s.awready <= 1'b1;
			s.wready  <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready_out = s.awready;
	assign s_axi_wready_out  = s.wready;
	assign s_axi_bresp_out   = s.bresp;
	assign s_axi_bvalid_out  = s.bvalid;
	assign s_axi_arready_out = s.arready;
	assign s_axi_rdata_out   = s.rdata;
	assign s_axi_rresp_out   = s.rresp;
	assign s_axi_rvalid_out  = s.rvalid;
	assign reg_wr_out        = s.wr_pulse;
	assign reg_wr_addr_out   = s.awaddr;
	assign reg_wdata_out     = s.wdata;
	assign reg_wstrb_out     = s.wstrb;
	assign reg_rd_addr_out   = s_axi_araddr_in;

endmodule

// *** rtl/bsfc_host_ctrl.sv ***
// Host-side controller for a boot-sector parallel flash: register file and pin sequencer.
// Assumes software composes command sequences as single bus cycles through the CMD register.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Commands reach the flash as ordinary write cycles into its command register.
// - In unlock-bypass mode a program takes two write cycles instead of four.
// - Erase may be suspended indefinitely, other sectors used, then resumed.
// - The host can put the flash into standby, cutting its activity.
// - Separate active-low select, write and output strobes keep the bus contention-free.
module bsfc_host_ctrl (
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic [19:0]      flash_addr_out,
	input  wire logic [15:0] data_lines_in,
	output logic [15:0]      data_lines_out,
	output logic [1:0]       data_lines_oe_n_out,
	output logic             flash_ce_n_out,
	output logic             flash_we_n_out,
	output logic             flash_oe_n_out,
	output logic             flash_reset_n_out,
	output logic             flash_byte_n_out,
	input  wire logic        op_done_pin_n_in
);

	typedef struct packed {
		bsfc_pkg::bsfc_state_t st;
		logic [3:0]            cnt;
		logic [1:0]            op;
		logic                  polling;
		logic                  last_tgl;
		logic                  byte_mode;
		logic                  byte_n;
		logic                  standby;
		logic                  hold_reset;
		logic [19:0]           addr;
		logic [15:0]           wdata;
		logic [15:0]           rdata;
		logic                  done;
		logic                  refused;
		logic                  ce_n;
		logic                  we_n;
		logic                  oe_n;
		logic [1:0]            dq_oe_n;
		logic [15:0]           dq_out;
		logic [19:0]           fa;
		logic                  reset_n;
		logic [15:0]           dq_s1;
		logic [15:0]           dq_s2;
		logic                  rdy_s1;
		logic                  rdy_s2;
	} bsfc_host_state_t;

	bsfc_host_state_t s;
	bsfc_host_state_t next_s;

	logic        reg_wr;
	logic [7:0]  reg_wr_addr;
	logic [31:0] reg_wdata;
	logic [3:0]  reg_wstrb;
	logic [7:0]  reg_rd_addr;
	logic [31:0] wval;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic reg_hit(input logic [7:0] a);
		case (a)
			bsfc_pkg::REG_CTRL, bsfc_pkg::REG_ADDR, bsfc_pkg::REG_WDATA,
			bsfc_pkg::REG_CMD, bsfc_pkg::REG_STATUS, bsfc_pkg::REG_RDATA: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] reg_read(input bsfc_host_state_t r, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			bsfc_pkg::REG_CTRL: begin
				v[bsfc_pkg::CTRL_BYTE]    = r.byte_mode;
				v[bsfc_pkg::CTRL_STANDBY] = r.standby;
				v[bsfc_pkg::CTRL_RESET]   = r.hold_reset;
			end
			bsfc_pkg::REG_ADDR:  v = {12'h000, r.addr};
			bsfc_pkg::REG_WDATA: v = {16'h0000, r.wdata};
			bsfc_pkg::REG_CMD:   v = {30'h0, r.op};
			bsfc_pkg::REG_STATUS: begin
				v[bsfc_pkg::STAT_BUSY]    = (r.st != bsfc_pkg::BSFC_IDLE);
				v[bsfc_pkg::STAT_READY]   = r.rdy_s2;
				v[bsfc_pkg::STAT_DONE]    = r.done;
				v[bsfc_pkg::STAT_REFUSED] = r.refused;
			end
			bsfc_pkg::REG_RDATA: v = {16'h0000, r.rdata};
			default:             v = 32'h0;
		endcase
		reg_read = v;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] m;
		m = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		merge = m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	bsfc_axil_slave u_axil (
		.ref_clk_in        (ref_clk_in),
		.rstn_in           (rstn_in),
		.s_axi_awaddr_in   (s_axi_awaddr_in),
		.s_axi_awvalid_in  (s_axi_awvalid_in),
		.s_axi_awready_out (s_axi_awready_out),
		.s_axi_wdata_in    (s_axi_wdata_in),
		.s_axi_wstrb_in    (s_axi_wstrb_in),
		.s_axi_wvalid_in   (s_axi_wvalid_in),
		.s_axi_wready_out  (s_axi_wready_out),
		.s_axi_bresp_out   (s_axi_bresp_out),
		.s_axi_bvalid_out  (s_axi_bvalid_out),
		.s_axi_bready_in   (s_axi_bready_in),
		.s_axi_araddr_in   (s_axi_araddr_in),
		.s_axi_arvalid_in  (s_axi_arvalid_in),
		.s_axi_arready_out (s_axi_arready_out),
		.s_axi_rdata_out   (s_axi_rdata_out),
		.s_axi_rresp_out   (s_axi_rresp_out),
		.s_axi_rvalid_out  (s_axi_rvalid_out),
		.s_axi_rready_in   (s_axi_rready_in),
		.reg_wr_out        (reg_wr),
		.reg_wr_addr_out   (reg_wr_addr),
		.reg_wdata_out     (reg_wdata),
		.reg_wstrb_out     (reg_wstrb),
		.reg_wr_err_in     (!reg_hit(reg_wr_addr)),
		.reg_rd_addr_out   (reg_rd_addr),
		.reg_rdata_in      (reg_read(s, reg_rd_addr)),
		.reg_rd_err_in     (!reg_hit(reg_rd_addr))
	);

	assign wval = merge(reg_read(s, reg_wr_addr), reg_wdata, reg_wstrb);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_s = s;
		next_s.dq_s1  = data_lines_in;
		next_s.dq_s2  = s.dq_s1;
		next_s.rdy_s1 = !op_done_pin_n_in;
		next_s.rdy_s2 = s.rdy_s1;
		// Clears are applied first so that a same-cycle completion still sets.
		if (reg_wr) begin
			case (reg_wr_addr)
				bsfc_pkg::REG_CTRL: begin
					next_s.byte_mode  = wval[bsfc_pkg::CTRL_BYTE];
					next_s.standby    = wval[bsfc_pkg::CTRL_STANDBY];
					next_s.hold_reset = wval[bsfc_pkg::CTRL_RESET];
				end
				bsfc_pkg::REG_ADDR:  next_s.addr  = wval[19:0];
				bsfc_pkg::REG_WDATA: next_s.wdata = wval[15:0];
				bsfc_pkg::REG_STATUS: begin
					if (reg_wstrb[0] && reg_wdata[bsfc_pkg::STAT_DONE]) begin
						next_s.done = 1'b0;
					end
					if (reg_wstrb[0] && reg_wdata[bsfc_pkg::STAT_REFUSED]) begin
						next_s.refused = 1'b0;
					end
				end
				bsfc_pkg::REG_CMD: begin
					// Every write or read is its own select cycle, so unlock and bypass sequences
					// are composed by software one cycle per command.
					if (wval[1:0] != bsfc_pkg::OP_NONE) begin
						if (s.st == bsfc_pkg::BSFC_IDLE && !s.standby && !s.hold_reset) begin
							next_s.op      = wval[1:0];
							next_s.polling = 1'b0;
							next_s.st      = bsfc_pkg::BSFC_SETUP;
							next_s.cnt     = bsfc_pkg::SETUP_CYC - 4'h1;
							next_s.ce_n    = 1'b0;
							next_s.fa      = s.byte_mode ? s.addr : {1'b0, s.addr[18:0]};
							if (wval[1:0] == bsfc_pkg::OP_WRITE) begin
								next_s.dq_out  = s.byte_mode ? {8'h00, s.wdata[7:0]} : s.wdata;
								next_s.dq_oe_n = s.byte_mode ? 2'b10 : 2'b00;
							end
						end else begin
							next_s.refused = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
		case (s.st)
			bsfc_pkg::BSFC_IDLE: begin
				// Address pins are left as they were, letting the flash fall asleep.
				next_s.ce_n = next_s.ce_n | s.standby;
			end
			bsfc_pkg::BSFC_SETUP: begin
				if (s.cnt == 4'h0) begin
					next_s.st  = bsfc_pkg::BSFC_STROBE;
					next_s.cnt = bsfc_pkg::STROBE_CYC - 4'h1;
					if (s.op == bsfc_pkg::OP_WRITE) begin
						next_s.we_n = 1'b0;
					end else begin
						next_s.oe_n = 1'b0;
					end
				end else begin
					next_s.cnt = s.cnt - 4'h1;
				end
			end
			bsfc_pkg::BSFC_STROBE: begin
				if (s.cnt == 4'h0) begin
					next_s.we_n = 1'b1;
					next_s.oe_n = 1'b1;
					if (s.op != bsfc_pkg::OP_WRITE) begin
						next_s.rdata = s.byte_mode ? {8'h00, s.dq_s2[7:0]} : s.dq_s2;
					end
					next_s.st  = bsfc_pkg::BSFC_HOLD;
					next_s.cnt = bsfc_pkg::HOLD_CYC - 4'h1;
				end else begin
					next_s.cnt = s.cnt - 4'h1;
				end
			end
			bsfc_pkg::BSFC_HOLD: begin
				if (s.cnt == 4'h0) begin
					next_s.ce_n    = 1'b1;
					next_s.dq_oe_n = 2'b11;
					if (s.op == bsfc_pkg::OP_POLL) begin
						next_s.st = bsfc_pkg::BSFC_CMPR;
					end else begin
						next_s.st   = bsfc_pkg::BSFC_IDLE;
						next_s.done = 1'b1;
					end
				end else begin
					next_s.cnt = s.cnt - 4'h1;
				end
			end
			bsfc_pkg::BSFC_CMPR: begin
				// The toggle bit stops toggling once the embedded algorithm ends.
				if (s.polling && s.rdata[bsfc_pkg::TOGGLE_BIT] == s.last_tgl) begin
					next_s.st      = bsfc_pkg::BSFC_IDLE;
					next_s.done    = 1'b1;
					next_s.polling = 1'b0;
				end else begin
					next_s.polling  = 1'b1;
					next_s.last_tgl = s.rdata[bsfc_pkg::TOGGLE_BIT];
					next_s.st       = bsfc_pkg::BSFC_SETUP;
					next_s.cnt      = bsfc_pkg::SETUP_CYC - 4'h1;
					next_s.ce_n     = 1'b0;
				end
			end
			default: next_s.st = bsfc_pkg::BSFC_IDLE;
		endcase
		if (next_s.hold_reset) begin
			next_s.st      = bsfc_pkg::BSFC_IDLE;
			next_s.polling = 1'b0;
			next_s.ce_n    = 1'b1;
			next_s.we_n    = 1'b1;
			next_s.oe_n    = 1'b1;
			next_s.dq_oe_n = 2'b11;
		end
		next_s.reset_n = !next_s.hold_reset;
		next_s.byte_n  = !next_s.byte_mode;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			s            <= '0;
			s.st         <= bsfc_pkg::BSFC_IDLE;
			s.byte_mode  <= bsfc_pkg::BYTE_RST;
			s.byte_n     <= !bsfc_pkg::BYTE_RST;
			s.standby    <= bsfc_pkg::STANDBY_RST;
			s.hold_reset <= bsfc_pkg::RESET_RST;
			s.ce_n       <= 1'b1;
			s.we_n       <= 1'b1;
			s.oe_n       <= 1'b1;
			s.dq_oe_n    <= 2'b11;
		end else begin
			s <= next_s;
		end
	end

	assign flash_addr_out      = s.fa;
	assign data_lines_out      = s.dq_out;
	assign data_lines_oe_n_out = s.dq_oe_n;
	assign flash_ce_n_out      = s.ce_n;
	assign flash_we_n_out      = s.we_n;
	assign flash_oe_n_out      = s.oe_n;
	assign flash_reset_n_out   = s.reset_n;
	assign flash_byte_n_out    = s.byte_n;

	////////////////////////////////////////////////////////////////////////////////

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	property p_no_contention;
		!flash_oe_n_out |-> data_lines_oe_n_out == 2'b11;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("Bus driven during read.");

	property p_byte_lane;
		(s.byte_mode && s.st == bsfc_pkg::BSFC_STROBE) |-> data_lines_oe_n_out[1];
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("Upper lane driven in byte mode.");

	property p_word_addr;
		(!flash_byte_n_out == 1'b0 && s.st == bsfc_pkg::BSFC_STROBE) |-> !flash_addr_out[19];
	endproperty
	a_word_addr: assert property (p_word_addr) else $error("Word address out of range.");

	sequence s_we_pulse;
		!flash_we_n_out [*8] ##1 flash_we_n_out;
	endsequence
	property p_write_cycle;
		(s.st == bsfc_pkg::BSFC_SETUP && s.op == bsfc_pkg::OP_WRITE && s.cnt == 4'h0
			&& !next_s.hold_reset) |=> s_we_pulse;
	endproperty
	a_write_cycle: assert property (p_write_cycle) else $error("Write strobe width wrong.");

	property p_reset_abort;
		s.hold_reset |-> (flash_ce_n_out && !flash_reset_n_out && s.st == bsfc_pkg::BSFC_IDLE);
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("Reset did not abort cycle.");

	property p_addr_still;
		(s.st == bsfc_pkg::BSFC_IDLE && $past(s.st) == bsfc_pkg::BSFC_IDLE) |-> $stable(flash_addr_out);
	endproperty
	a_addr_still: assert property (p_addr_still) else $error("Address moved while idle.");

	property p_standby;
		(s.standby && s.st == bsfc_pkg::BSFC_IDLE) |=> flash_ce_n_out;
	endproperty
	a_standby: assert property (p_standby) else $error("Select low in standby.");

	property p_cycle_gap;
		(s.st == bsfc_pkg::BSFC_HOLD && s.cnt == 4'h0) |=> flash_ce_n_out && data_lines_oe_n_out == 2'b11;
	endproperty
	a_cycle_gap: assert property (p_cycle_gap) else $error("No gap between bus cycles.");

	sequence s_poll_settled;
		s.st == bsfc_pkg::BSFC_CMPR && s.polling
			&& s.rdata[bsfc_pkg::TOGGLE_BIT] == s.last_tgl && !next_s.hold_reset;
	endsequence
	property p_poll_done;
		s_poll_settled |=> (s.st == bsfc_pkg::BSFC_IDLE && s.done) ##1 !s.polling;
	endproperty
	a_poll_done: assert property (p_poll_done) else $error("Poll end not reported.");

endmodule

// *** test/bsfc_flash_model.sv ***
// Behavioural boot-sector flash on the far side of the host controller.
// Assumes strobe-level pins from the controller; busy time is counted on the bench clock.
`timescale 1ns/1ps
module bsfc_flash_model #(
	parameter int          BUSY_CYC = 40,
	parameter logic [19:0] PROT_LO  = 20'h04000,
	parameter logic [19:0] PROT_HI  = 20'h05FFF
) (
	input  wire logic        clk_in,
	input  wire logic [19:0] addr_in,
	input  wire logic [15:0] dq_in,
	output logic      [15:0] dq_out,
	input  wire logic        ce_n_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        reset_n_in,
	input  wire logic        byte_n_in,
	input  wire logic        low_vcc_in,
	input  wire logic        unprot_in,
	output logic             busy_n_out
);
	logic [7:0]  mem [0:511];
	logic [8:0]  ix;
	logic        we_q, oe_q, tog, pol, drv;
	logic [15:0] last;
	logic [19:0] ba;
	logic        prot;
	int          cnt;
	initial begin
		foreach (mem[i])
			mem[i] = 8'hFF;
		{we_q, oe_q, tog, pol, last} = '0;
		cnt = 0;
	end
	assign ix = byte_n_in ? {addr_in[7:0], 1'b0} : addr_in[8:0];
	assign busy_n_out = (cnt == 0);
	assign drv = !ce_n_in && !oe_n_in && reset_n_in;
	// One 8 Kbyte boot sector stays locked unless the temporary unprotect input is high.
	assign ba   = byte_n_in ? {addr_in[18:0], 1'b0} : addr_in;
	assign prot = !unprot_in && ba >= PROT_LO && ba <= PROT_HI;
	// Released lines show the inverse of the last wire value, so stale data never passes.
	always_comb begin
		if (!drv)
			dq_out = ~last;
		else if (cnt != 0)
			dq_out = {8'h00, pol, tog, 6'h00};
		else
			dq_out = {byte_n_in ? mem[ix + 9'h001] : ~last[15:8], mem[ix]};
	end
	always @(negedge clk_in) begin
		we_q <= we_n_in;
		oe_q <= oe_n_in;
		last <= dq_in;
		if (!reset_n_in)
			cnt <= 0;
		else if (!we_q && we_n_in && !ce_n_in && cnt == 0 && !prot && !low_vcc_in) begin
			mem[ix] <= dq_in[7:0];
			if (byte_n_in)
				mem[ix + 9'h001] <= dq_in[15:8];
			pol <= ~dq_in[7];
			cnt <= BUSY_CYC;
		end else if (cnt != 0)
			cnt <= cnt - 1;
		if (oe_q && !oe_n_in && !ce_n_in && cnt != 0)
			tog <= ~tog;
	end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the boot flash host controller, driving its AXI4-Lite port.
// Assumes the behavioural flash model on the pins and a 40 MHz clock.
`timescale 1ns/1ps
module tb;
	logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, lane_oe_n, rsp;
	logic [19:0] faddr;
	logic [15:0] dut_dq, fm_dq, dq_w;
	logic        ce_n, we_n, oe_n, frst_n, byte_n, busy_n, low_vcc, unprot;
	int          fail_count, n_tests, cyc;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	assign dq_w[7:0]  = lane_oe_n[0] ? fm_dq[7:0] : dut_dq[7:0];
	assign dq_w[15:8] = lane_oe_n[1] ? fm_dq[15:8] : dut_dq[15:8];
	bsfc_host_ctrl DUT (.ref_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .flash_addr_out(faddr), .data_lines_in(dq_w),
		.data_lines_out(dut_dq), .data_lines_oe_n_out(lane_oe_n), .flash_ce_n_out(ce_n),
		.flash_we_n_out(we_n), .flash_oe_n_out(oe_n), .flash_reset_n_out(frst_n),
		.flash_byte_n_out(byte_n), .op_done_pin_n_in(busy_n));
	bsfc_flash_model fm (.clk_in(clk), .addr_in(faddr), .dq_in(dq_w), .dq_out(fm_dq),
		.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .reset_n_in(frst_n),
		.byte_n_in(byte_n), .busy_n_out(busy_n), .low_vcc_in(low_vcc),
		.unprot_in(unprot));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	// Polls until the pin cycle ends, then clears the sticky done and refused flags.
	task automatic wait_done;
		do
			rdr(bsfc_pkg::REG_STATUS);
		while (rd[bsfc_pkg::STAT_DONE] !== 1'b1);
		wr(bsfc_pkg::REG_STATUS, 32'h0000_000C);
	endtask
	task automatic op(input logic [31:0] c);
		wr(bsfc_pkg::REG_CMD, c);
		wait_done();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, low_vcc, unprot} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({ce_n, we_n, oe_n, lane_oe_n, byte_n, frst_n}), 32'h0000_007F);
		rdr(bsfc_pkg::REG_CTRL);
		chk(rd, 32'h0000_0000);
		wr(bsfc_pkg::REG_ADDR, 32'h000F_FF12);
		wr(bsfc_pkg::REG_WDATA, 32'h0000_A5C3);
		op(32'h0000_0001);
		chk(32'(faddr), 32'h0007_FF12);
		wr(bsfc_pkg::REG_CMD, 32'h0000_0002);
		wr(bsfc_pkg::REG_CMD, 32'h0000_0002);
		wait_done();
		chk(32'(rd[3:1]), 32'h0000_0007);
		rdr(bsfc_pkg::REG_RDATA);
		chk(32'(rd[7]), 32'h0000_0000);
		op(32'h0000_0003);
		rdr(bsfc_pkg::REG_STATUS);
		chk(32'(rd[1]), 32'h0000_0000);
		wr(bsfc_pkg::REG_CTRL, 32'h0000_0001);
		wr(bsfc_pkg::REG_ADDR, 32'h0000_0041);
		wr(bsfc_pkg::REG_WDATA, 32'h0000_1234);
		op(32'h0000_0001);
		op(32'h0000_0003);
		op(32'h0000_0002);
		rdr(bsfc_pkg::REG_RDATA);
		chk(rd, 32'h0000_0034);
		chk(32'(byte_n), 32'h0000_0000);
		wr(bsfc_pkg::REG_ADDR, 32'h0000_4010);
		wr(bsfc_pkg::REG_WDATA, 32'h0000_005A);
		op(32'h0000_0001);
		op(32'h0000_0003);
		op(32'h0000_0002);
		rdr(bsfc_pkg::REG_RDATA);
		chk(rd, 32'h0000_00FF);
		unprot <= 1'b1;
		op(32'h0000_0001);
		op(32'h0000_0003);
		op(32'h0000_0002);
		rdr(bsfc_pkg::REG_RDATA);
		chk(rd, 32'h0000_005A);
		unprot <= 1'b0;
		wr(bsfc_pkg::REG_CTRL, 32'h0000_0000);
		wr(bsfc_pkg::REG_ADDR, 32'h0000_0012);
		op(32'h0000_0002);
		rdr(bsfc_pkg::REG_RDATA);
		chk(rd, 32'h0000_A5C3);
		wr(8'h18, 32'h0000_0001);
		chk(32'(rsp), 32'(bsfc_pkg::RESP_SLVERR));
		rdr(8'h18);
		chk({rd[31:2], rsp}, 32'(bsfc_pkg::RESP_SLVERR));
		wr(bsfc_pkg::REG_CTRL, 32'h0000_0002);
		wr(bsfc_pkg::REG_CMD, 32'h0000_0002);
		rdr(bsfc_pkg::REG_STATUS);
		chk(32'({rd[3], ce_n}), 32'h0000_0003);
		wr(bsfc_pkg::REG_CTRL, 32'h0000_0000);
		wr(bsfc_pkg::REG_STATUS, 32'h0000_000C);
		wr(bsfc_pkg::REG_CMD, 32'h0000_0002);
		wr(bsfc_pkg::REG_CTRL, 32'h0000_0004);
		rdr(bsfc_pkg::REG_STATUS);
		chk(32'({rd[0], ce_n, frst_n}), 32'h0000_0002);
		wr(bsfc_pkg::REG_CTRL, 32'h0000_0000);
		op(32'h0000_0002);
		rdr(bsfc_pkg::REG_RDATA);
		chk(rd, 32'h0000_A5C3);
		wr(bsfc_pkg::REG_WDATA, 32'h0000_0F0F);
		low_vcc <= 1'b1;
		op(32'h0000_0001);
		low_vcc <= 1'b0;
		op(32'h0000_0003);
		op(32'h0000_0002);
		rdr(bsfc_pkg::REG_RDATA);
		chk(rd, 32'h0000_A5C3);
		tally_and_finish();
	end
endmodule
